/* File: rtl/bsrc_pkg.sv */
package bsrc_pkg;

  // Command codes seen by the block's command port
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
  localparam logic [7:0] CMD_CLEAR_FAULT = 8'h03;
  localparam logic [7:0] CMD_TON_DELAY = 8'h60;
  localparam logic [7:0] CMD_TON_RISE = 8'h61;
  localparam logic [7:0] CMD_TOFF_DELAY = 8'h64;
  localparam logic [7:0] CMD_VOUT_RDG = 8'h8B;
  localparam logic [7:0] CMD_REF_TRIM = 8'hD0;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'hD1;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'hD2;
  localparam logic [7:0] CMD_FAULT_PCT = 8'hD3;

  // Field positions
  localparam int OP_ON_BIT = 7;
  localparam int OP_MARGIN_LSB = 4;
  localparam int CFG_USE_PIN_BIT = 0;
  localparam int CFG_USE_OP_BIT = 1;
  localparam int PCT_OV_LSB = 0;
  localparam int PCT_UV_LSB = 5;
  localparam int PCT_PG_LSB = 10;
  localparam int PCT_W = 5;

  localparam logic [1:0] MARGIN_NONE = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HIGH = 2'h2;

  // Power-up values, standing in for the stored configuration
  localparam logic [15:0] OPERATION_RST = 16'h0000;
  localparam logic [15:0] ON_OFF_CFG_RST = 16'h0003;
  localparam logic [15:0] TON_DELAY_RST = 16'h0000;
  localparam logic [15:0] TOFF_DELAY_RST = 16'h0000;
  localparam logic [15:0] TON_RISE_RST = 16'h0009;
  localparam logic [15:0] REF_TRIM_RST = 16'h0000;
  localparam logic [15:0] MARGIN_HIGH_RST = 16'h000F;
  localparam logic [15:0] MARGIN_LOW_RST = 16'h00F1;
  localparam logic [15:0] FAULT_PCT_RST = 16'h2210;

  // Reference code, one step is about 1.953 mV
  localparam int REF_W = 10;
  localparam logic [REF_W-1:0] REF_NOM = 10'd307;
  localparam int TRIM_MIN = -61;
  localparam int TRIM_MAX = 30;
  localparam int TOTAL_MIN = -92;
  localparam int TOTAL_MAX = 30;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RAMP_UNIT_NS = 1000;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_NS / CLK_PERIOD_NS;
  localparam int PREBIAS_PULSES = 128;

  // Frequency-set pin, resistance in kilo-ohm
  localparam logic [9:0] FS_LOW_LIMIT = 10'd5;
  localparam logic [9:0] FS_HIGH_LIMIT = 10'd300;
  localparam logic [9:0] FS_BOUND_1 = 10'd14;
  localparam logic [9:0] FS_BOUND_2 = 10'd22;
  localparam logic [9:0] FS_BOUND_3 = 10'd33;
  localparam logic [9:0] FS_BOUND_4 = 10'd47;
  localparam logic [9:0] FS_BOUND_5 = 10'd71;
  localparam logic [9:0] FS_BOUND_6 = 10'd110;
  localparam logic [9:0] FS_BOUND_7 = 10'd169;
  localparam logic [2:0] FREQ_250K = 3'h0;
  localparam logic [2:0] FREQ_1000K = 3'h7;

  typedef enum logic [2:0] {
    SEQ_OFF,
    SEQ_ON_DELAY,
    SEQ_SOFT_START,
    SEQ_REGULATE,
    SEQ_OFF_DELAY
  } bsrc_seq_type;

endpackage

/* File: rtl/bsrc_sequencer.sv */
// Behaviour
// RL1 - Gating: UVLO alone, or pin/command/both
// RL2 - Wait turn-on delay before regulating
// RL3 - Keep regulating through turn-off delay
// RL4 - Delays count whole soft-start periods
// RL5 - Release power-good only inside window
// RL6 - UVLO-only option converts without pin/command
// RL7 - OPERATION bit 7 enables, others margin
// RL8 - No pulses until ramp exceeds feedback
// RL9 - Low-side on-time grows over 128 pulses
// RL10 - Overvoltage answered always, even when off
// RL11 - Seven-bit trim, -20% to +10%
// RL12 - Trim plus margin within -30%..+10%
// RL13 - Power-up target 600 mV plus stored offsets
// RL14 - Margin states none, high, low
// RL15 - Reference equals nominal plus trim plus margin
// RL16 - Fault/PG limits from fixed nominal only
// RL17 - Average output samples into 8Bh register
// RL18 - Decode frequency pin into eight settings
// RL19 - Out-of-range pin picks 250k or 1M
// RL20 - Latch frequency until rail reset
// RL21 - Ramp reference from zero at rise rate
// RL22 - Power-good low while off or starting
// RL23 - Trim/margin changes move target live
`timescale 1ns/1ps
module bsrc_sequencer
  import bsrc_pkg::*;
#(
  parameter int AVG_LOG2 = 3
) (
  // Clock and power-on reset from the internal 6 V rail
  input wire logic clk_sys,
  input wire logic arst_n,
  // Gating inputs
  input wire logic uvlo_ok,
  input wire logic control_input_pin,
  // Analog comparator results
  input wire logic ref_over_fdbk,
  input wire logic pg_in_window,
  input wire logic ov_detect,
  input wire logic switch_pulse,
  // Converter samples
  input wire logic vout_valid,
  input wire logic [15:0] vout_sample,
  input wire logic fs_valid,
  input wire logic [9:0] fs_kohm,
  // Command port from the bus engine
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ack_r,
  output logic cmd_err_r,
  output logic [15:0] cmd_rdata_r,
  // Power stage control
  output logic convert_en_r,
  output logic switching_en_r,
  output logic [6:0] ls_on_step_r,
  output logic ls_complementary_r,
  output logic ls_force_on_r,
  output logic ov_fault_r,
  // Reference and limits
  output logic [REF_W-1:0] ref_code_r,
  output logic [REF_W-1:0] ov_thr_r,
  output logic [REF_W-1:0] uv_thr_r,
  output logic [REF_W-1:0] pg_lo_thr_r,
  output logic [REF_W-1:0] pg_hi_thr_r,
  // Open-drain power-good and frequency
  output logic power_good_output_o,
  output logic power_good_output_oe_r,
  output logic [2:0] freq_sel_r
);

  if (AVG_LOG2 < 1 || AVG_LOG2 > 8) begin : g_chk
    $error("bsrc_sequencer supports AVG_LOG2 from 1 to 8");
  end

  function automatic logic [2:0] fs_decode(input logic [9:0] kohm);
    logic [2:0] sel;
    sel = FREQ_1000K;
    if (kohm < FS_LOW_LIMIT) sel = FREQ_250K; // see RL19
    else if (kohm > FS_HIGH_LIMIT) sel = FREQ_1000K; // see RL19
    else if (kohm < FS_BOUND_1) sel = 3'h0;
    else if (kohm < FS_BOUND_2) sel = 3'h1;
    else if (kohm < FS_BOUND_3) sel = 3'h2;
    else if (kohm < FS_BOUND_4) sel = 3'h3;
    else if (kohm < FS_BOUND_5) sel = 3'h4;
    else if (kohm < FS_BOUND_6) sel = 3'h5;
    else if (kohm < FS_BOUND_7) sel = 3'h6;
    return sel;
  endfunction

  function automatic logic signed [11:0] clampi(input logic signed [11:0] v,
                                                input int lo, input int hi);
    logic signed [11:0] r;
    r = v;
    if (v < 12'(lo)) r = 12'(lo);
    if (v > 12'(hi)) r = 12'(hi);
    return r;
  endfunction

  function automatic logic [REF_W-1:0] pct_of_nom(input logic [PCT_W-1:0] f);
    logic [15:0] p;
    p = 16'(REF_NOM) * 16'(f);
    return REF_W'(p >> 7);
  endfunction

  assign power_good_output_o = 1'b0;

  // Configuration registers and command port
  logic [15:0] op_r, op_nxt, cfg_r, cfg_nxt, ton_r, ton_nxt, toff_r, toff_nxt;
  logic [15:0] rise_r, rise_nxt, trim_r, trim_nxt, mhi_r, mhi_nxt, mlo_r, mlo_nxt;
  logic [15:0] pct_r, pct_nxt, vout_rd_r;
  logic ack_nxt, err_nxt, clear_fault;
  logic [15:0] rdata_nxt;

  always_comb begin
    op_nxt = op_r;
    cfg_nxt = cfg_r;
    ton_nxt = ton_r;
    toff_nxt = toff_r;
    rise_nxt = rise_r;
    trim_nxt = trim_r;
    mhi_nxt = mhi_r;
    mlo_nxt = mlo_r;
    pct_nxt = pct_r;
    ack_nxt = cmd_wr | cmd_rd;
    err_nxt = 1'b0;
    rdata_nxt = 16'h0000;
    clear_fault = 1'b0;
    if (cmd_wr) begin
      case (cmd_code)
        CMD_OPERATION: op_nxt = cmd_wdata; // see RL7
        CMD_ON_OFF_CFG: cfg_nxt = cmd_wdata;
        CMD_TON_DELAY: ton_nxt = cmd_wdata;
        CMD_TOFF_DELAY: toff_nxt = cmd_wdata;
        CMD_TON_RISE: rise_nxt = cmd_wdata;
        CMD_REF_TRIM: trim_nxt = {9'h000, cmd_wdata[6:0]}; // see RL11
        CMD_MARGIN_HIGH: mhi_nxt = {8'h00, cmd_wdata[7:0]};
        CMD_MARGIN_LOW: mlo_nxt = {8'h00, cmd_wdata[7:0]};
        CMD_FAULT_PCT: pct_nxt = {1'b0, cmd_wdata[14:0]};
        CMD_CLEAR_FAULT: clear_fault = 1'b1;
        default: err_nxt = 1'b1;
      endcase
    end else if (cmd_rd) begin
      case (cmd_code)
        CMD_OPERATION: rdata_nxt = op_r;
        CMD_ON_OFF_CFG: rdata_nxt = cfg_r;
        CMD_TON_DELAY: rdata_nxt = ton_r;
        CMD_TOFF_DELAY: rdata_nxt = toff_r;
        CMD_TON_RISE: rdata_nxt = rise_r;
        CMD_REF_TRIM: rdata_nxt = trim_r;
        CMD_MARGIN_HIGH: rdata_nxt = mhi_r;
        CMD_MARGIN_LOW: rdata_nxt = mlo_r;
        CMD_FAULT_PCT: rdata_nxt = pct_r;
        CMD_VOUT_RDG: rdata_nxt = vout_rd_r; // see RL17
        default: err_nxt = 1'b1;
      endcase
    end
  end

  // Stored settings come back at every power-on reset
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_r <= OPERATION_RST;
      cfg_r <= ON_OFF_CFG_RST;
      ton_r <= TON_DELAY_RST;
      toff_r <= TOFF_DELAY_RST;
      rise_r <= TON_RISE_RST;
      trim_r <= REF_TRIM_RST; // see RL13
      mhi_r <= MARGIN_HIGH_RST;
      mlo_r <= MARGIN_LOW_RST;
      pct_r <= FAULT_PCT_RST;
      cmd_ack_r <= 1'b0;
      cmd_err_r <= 1'b0;
      cmd_rdata_r <= 16'h0000;
    end else begin
      op_r <= op_nxt;
      cfg_r <= cfg_nxt;
      ton_r <= ton_nxt;
      toff_r <= toff_nxt;
      rise_r <= rise_nxt;
      trim_r <= trim_nxt;
      mhi_r <= mhi_nxt;
      mlo_r <= mlo_nxt;
      pct_r <= pct_nxt;
      cmd_ack_r <= ack_nxt;
      cmd_err_r <= err_nxt;
      cmd_rdata_r <= rdata_nxt;
    end
  end

  // Ramp timing: a microsecond base, then one reference step per rise unit
  logic us_tick, ss_tick;

  bsrc_tick_div #(.CNT_W(8)) u_us_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .en(1'b1),
    .period(8'(RAMP_UNIT_CYC)),
    .tick_r(us_tick)
  );

  bsrc_tick_div #(.CNT_W(17)) u_ramp_div (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .en(us_tick),
    .period({1'b0, rise_r} + 17'h0_0001),
    .tick_r(ss_tick)
  );

  // Reference target
  logic signed [11:0] trim_c, margin_c, total_c;
  logic [REF_W-1:0] target;
  logic [1:0] margin_mode;
  logic gate;

  always_comb begin
    trim_c = clampi(12'($signed(trim_r[6:0])), TRIM_MIN, TRIM_MAX); // see RL11
    margin_mode = op_r[OP_MARGIN_LSB +: 2];
    case (margin_mode) // see RL14
      MARGIN_HIGH: margin_c = 12'($signed(mhi_r[7:0]));
      MARGIN_LOW: margin_c = 12'($signed(mlo_r[7:0]));
      default: margin_c = 12'sh000;
    endcase
    total_c = clampi(trim_c + margin_c, TOTAL_MIN, TOTAL_MAX); // see RL12
    target = REF_W'($signed({2'b00, REF_NOM}) + total_c); // see RL15
    gate = uvlo_ok // see RL6
      && (!cfg_r[CFG_USE_PIN_BIT] || control_input_pin) // see RL1
      && (!cfg_r[CFG_USE_OP_BIT] || op_r[OP_ON_BIT]); // see RL7
  end

  // Sequencer
  bsrc_seq_type st_r, st_nxt;
  logic [REF_W-1:0] ref_nxt, sub_r, sub_nxt;
  logic [15:0] unit_r, unit_nxt;
  logic [7:0] pulse_r, pulse_nxt;
  logic swen_nxt, ov_nxt, pg_oe_nxt, restart, dly_done_on, dly_done_off;

  always_comb begin
    st_nxt = st_r;
    ref_nxt = ref_code_r;
    swen_nxt = switching_en_r;
    pulse_nxt = pulse_r;
    restart = 1'b0;
    sub_nxt = sub_r;
    unit_nxt = unit_r;
    // Delays count whole soft-start periods of REF_NOM ramp steps
    if (ss_tick) begin // see RL4
      if (sub_r == REF_NOM - 1'b1) begin
        sub_nxt = '0;
        unit_nxt = unit_r + 1'b1;
      end else begin
        sub_nxt = sub_r + 1'b1;
      end
    end
    dly_done_on = unit_r >= ton_r;
    dly_done_off = unit_r >= toff_r;
    case (st_r)
      SEQ_OFF: begin
        ref_nxt = '0;
        swen_nxt = 1'b0;
        pulse_nxt = 8'h00;
        restart = 1'b1;
        if (gate) st_nxt = SEQ_ON_DELAY; // see RL2
      end
      SEQ_ON_DELAY: begin
        if (!gate) st_nxt = SEQ_OFF;
        else if (dly_done_on) st_nxt = SEQ_SOFT_START; // see RL2
      end
      SEQ_SOFT_START: begin
        if (ss_tick && ref_code_r < target) ref_nxt = ref_code_r + 1'b1; // see RL21
        if (ref_over_fdbk) swen_nxt = 1'b1; // see RL8
        if (!gate) begin
          st_nxt = SEQ_OFF_DELAY;
          restart = 1'b1;
        end else if (ref_code_r >= target) begin
          st_nxt = SEQ_REGULATE;
        end
      end
      SEQ_REGULATE, SEQ_OFF_DELAY: begin
        // A pre-bias above the target must still hold the switch node quiet
        if (ref_over_fdbk) swen_nxt = 1'b1; // see RL8
        // Walk one step per tick so a new target causes no output jump
        if (ss_tick && ref_code_r < target) ref_nxt = ref_code_r + 1'b1; // see RL23
        if (ss_tick && ref_code_r > target) ref_nxt = ref_code_r - 1'b1; // see RL23
        if (st_r == SEQ_REGULATE && !gate) begin
          st_nxt = SEQ_OFF_DELAY; // see RL3
          restart = 1'b1;
        end else if (st_r == SEQ_OFF_DELAY && gate) begin
          st_nxt = SEQ_REGULATE;
        end else if (st_r == SEQ_OFF_DELAY && dly_done_off) begin
          st_nxt = SEQ_OFF; // see RL3
        end
      end
      default: st_nxt = SEQ_OFF;
    endcase
    if (swen_nxt && switch_pulse && pulse_r < 8'(PREBIAS_PULSES)) begin // see RL9
      pulse_nxt = pulse_r + 1'b1;
    end
    ov_nxt = ov_detect || (ov_fault_r && !clear_fault); // see RL10
    if (ov_nxt) begin
      st_nxt = SEQ_OFF; // see RL10
      swen_nxt = 1'b0;
    end
    if (restart) begin
      sub_nxt = '0;
      unit_nxt = 16'h0000;
    end
    pg_oe_nxt = !((st_nxt == SEQ_REGULATE || st_nxt == SEQ_OFF_DELAY) // see RL22
      && pg_in_window); // see RL5
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= SEQ_OFF;
      ref_code_r <= '0;
      switching_en_r <= 1'b0;
      convert_en_r <= 1'b0;
      pulse_r <= 8'h00;
      ls_on_step_r <= 7'h00;
      ls_complementary_r <= 1'b0;
      ls_force_on_r <= 1'b0;
      ov_fault_r <= 1'b0;
      sub_r <= '0;
      unit_r <= 16'h0000;
      power_good_output_oe_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      ref_code_r <= ref_nxt;
      switching_en_r <= swen_nxt;
      convert_en_r <= st_nxt == SEQ_SOFT_START || st_nxt == SEQ_REGULATE
        || st_nxt == SEQ_OFF_DELAY;
      pulse_r <= pulse_nxt;
      ls_on_step_r <= pulse_nxt[6:0]; // see RL9
      ls_complementary_r <= pulse_nxt == 8'(PREBIAS_PULSES); // see RL9
      ls_force_on_r <= ov_nxt; // see RL10
      ov_fault_r <= ov_nxt;
      sub_r <= sub_nxt;
      unit_r <= unit_nxt;
      power_good_output_oe_r <= pg_oe_nxt;
    end
  end

  // Fault limits track the nominal reference, never trim or margin
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ov_thr_r <= '0;
      uv_thr_r <= '0;
      pg_lo_thr_r <= '0;
      pg_hi_thr_r <= '0;
    end else begin
      ov_thr_r <= REF_NOM + pct_of_nom(pct_r[PCT_OV_LSB +: PCT_W]); // see RL16
      uv_thr_r <= REF_NOM - pct_of_nom(pct_r[PCT_UV_LSB +: PCT_W]); // see RL16
      pg_lo_thr_r <= REF_NOM - pct_of_nom(pct_r[PCT_PG_LSB +: PCT_W]); // see RL16
      pg_hi_thr_r <= REF_NOM + pct_of_nom(pct_r[PCT_PG_LSB +: PCT_W]); // see RL16
    end
  end

  // Output-voltage telemetry and frequency latch
  logic [15+AVG_LOG2:0] acc_r, acc_nxt, acc_sum;
  logic [AVG_LOG2-1:0] navg_r, navg_nxt;
  logic [15:0] vout_nxt;
  logic [2:0] freq_nxt;
  logic freq_lock_r, lock_nxt;

  always_comb begin
    acc_nxt = acc_r;
    navg_nxt = navg_r;
    vout_nxt = vout_rd_r;
    acc_sum = acc_r + (16+AVG_LOG2)'(vout_sample);
    if (vout_valid) begin // see RL17
      navg_nxt = navg_r + 1'b1;
      if (&navg_r) begin
        vout_nxt = 16'(acc_sum >> AVG_LOG2);
        acc_nxt = '0;
      end else begin
        acc_nxt = acc_sum;
      end
    end
    // Pin is ignored after the first decode until the next power-on reset
    freq_nxt = freq_sel_r;
    lock_nxt = freq_lock_r;
    if (!freq_lock_r && fs_valid) begin // see RL20
      freq_nxt = fs_decode(fs_kohm); // see RL18
      lock_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= '0;
      navg_r <= '0;
      vout_rd_r <= 16'h0000;
      freq_sel_r <= FREQ_250K;
      freq_lock_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      navg_r <= navg_nxt;
      vout_rd_r <= vout_nxt;
      freq_sel_r <= freq_nxt;
      freq_lock_r <= lock_nxt;
    end
  end

endmodule

/* File: rtl/bsrc_tick_div.sv */
`timescale 1ns/1ps
module bsrc_tick_div #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Rate control
  input wire logic en,
  input wire logic [CNT_W-1:0] period,
  // Output enable pulse
  output logic tick_r
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic tick_nxt;

  if (CNT_W < 2) begin : g_chk
    $error("bsrc_tick_div needs CNT_W of at least 2");
  end

  // A period of zero behaves as one, so the tick can never stall
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (en) begin
      if (cnt_r + 1'b1 >= period) begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

endmodule

/* File: verif/bsrc_sequencer_assertions.sv */
`timescale 1ns/1ps
module bsrc_sequencer_assertions
  import bsrc_pkg::*;
#(
  parameter int AVG_LOG2 = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Inputs seen by the block
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic ov_detect,
  input wire logic pg_in_window,
  input wire logic ref_over_fdbk,
  input wire logic fs_valid,
  // Outputs of the block
  input wire logic cmd_ack_r,
  input wire logic [15:0] cmd_rdata_r,
  input wire logic convert_en_r,
  input wire logic switching_en_r,
  input wire logic [6:0] ls_on_step_r,
  input wire logic ls_complementary_r,
  input wire logic ov_fault_r,
  input wire logic [REF_W-1:0] ref_code_r,
  input wire logic [REF_W-1:0] ov_thr_r,
  input wire logic [REF_W-1:0] pg_lo_thr_r,
  input wire logic power_good_output_o,
  input wire logic power_good_output_oe_r,
  input wire logic [2:0] freq_sel_r
);
  logic seen_r;
  logic seen_nxt;
  logic [1:0] up_r;
  logic [1:0] up_nxt;

  // Limits are recomputed from reset values, so give them a few edges to settle
  always_comb begin
    seen_nxt = seen_r | fs_valid;
    up_nxt = (up_r == 2'h3) ? up_r : up_r + 2'h1;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      seen_r <= 1'h0;
      up_r <= 2'h0;
    end else begin
      seen_r <= seen_nxt;
      up_r <= up_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  ack_follows_a: assert property ((cmd_wr || cmd_rd) |=> cmd_ack_r)
    else $error("no answer one cycle after a command");
  ack_only_a: assert property (!(cmd_wr || cmd_rd) |=> !cmd_ack_r)
    else $error("answer without a command");
  rdata_idle_a: assert property (!cmd_ack_r |-> cmd_rdata_r == 16'h0000)
    else $error("read data outside an answer");
  ov_response_a: assert property (ov_detect |=> ov_fault_r && !convert_en_r && !switching_en_r)
    else $error("overvoltage not answered");
  pg_held_a: assert property (!convert_en_r |-> power_good_output_oe_r)
    else $error("power good released while off");
  pg_release_a: assert property ($fell(power_good_output_oe_r) |-> $past(pg_in_window) && convert_en_r)
    else $error("power good released outside window");
  pg_pin_a: assert property (power_good_output_o == 1'h0)
    else $error("open drain pin driven high");
  freq_latch_a: assert property (seen_r |=> $stable(freq_sel_r))
    else $error("frequency changed after latch");
  limits_fixed_a: assert property (up_r == 2'h3 && !$past(cmd_wr && cmd_code == CMD_FAULT_PCT)
      |=> $stable(ov_thr_r) && $stable(pg_lo_thr_r))
    else $error("limits moved without a limit write");
  switch_gate_a: assert property ($rose(switching_en_r) |-> $past(ref_over_fdbk))
    else $error("switching before ramp passed feedback");
  ramp_zero_a: assert property ($rose(convert_en_r) |-> ref_code_r <= 10'h001)
    else $error("ramp did not start from zero");
  compl_after_a: assert property ($rose(ls_complementary_r) |-> $past(ls_on_step_r) == 7'h7f)
    else $error("complementary drive before 128 pulses");
endmodule

bind bsrc_sequencer bsrc_sequencer_assertions #(.AVG_LOG2(AVG_LOG2)) i_chk (.clk_sys, .arst_n,
  .cmd_wr, .cmd_rd, .cmd_code, .ov_detect, .pg_in_window, .ref_over_fdbk, .fs_valid,
  .cmd_ack_r,
  .cmd_rdata_r, .convert_en_r, .switching_en_r, .ls_on_step_r, .ls_complementary_r,
  .ov_fault_r, .ref_code_r, .ov_thr_r, .pg_lo_thr_r, .power_good_output_o,
  .power_good_output_oe_r, .freq_sel_r);

/* File: verif/bsrc_stage_model.sv */
`timescale 1ns/1ps
module bsrc_stage_model
  import bsrc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // From the block, and the pre-bias level from the bench
  input wire logic switching_en_r,
  input wire logic [REF_W-1:0] ref_code_r,
  input wire logic [REF_W-1:0] prebias_code,
  // Comparator and pulse feedback
  output logic ref_over_fdbk,
  output logic pg_in_window,
  output logic switch_pulse
);
  logic [REF_W-1:0] fdbk_r;
  logic [1:0] ph_r;

  // Output rests at the pre-bias level until the stage switches, then lags the reference
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      fdbk_r <= prebias_code;
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
      if (switching_en_r) begin
        fdbk_r <= ref_code_r;
      end
    end
  end

  assign ref_over_fdbk = ref_code_r > fdbk_r;
  assign switch_pulse = switching_en_r && (ph_r == 2'h3);
  // In window as soon as the output follows; the block must still wait for start-up to end
  assign pg_in_window = switching_en_r && (fdbk_r == ref_code_r);
endmodule

/* File: verif/test_buck_sequencing_and_reference_control.sv */
`timescale 1ns/1ps
module test_buck_sequencing_and_reference_control
  import bsrc_pkg::*;
;
  typedef struct {logic rd; logic err; logic [15:0] data;} bsrc_exp_type;
  bsrc_exp_type exp_q[$];
  bsrc_exp_type e;
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  logic uvlo_ok = 1'h0;
  logic control_input_pin = 1'h0;
  logic ov_detect = 1'h0;
  logic vout_valid = 1'h0;
  logic [15:0] vout_sample = 16'h0000;
  logic fs_valid = 1'h1;
  logic [9:0] fs_kohm = 10'h000;
  logic cmd_wr = 1'h0;
  logic cmd_rd = 1'h0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [REF_W-1:0] prebias_code = 10'h064;
  logic ref_over_fdbk, pg_in_window, switch_pulse, cmd_ack_r, cmd_err_r, convert_en_r;
  logic switching_en_r, ls_complementary_r, ov_fault_r, power_good_output_o;
  logic power_good_output_oe_r, ls_force_on_r;
  logic [REF_W-1:0] ov_thr_r, uv_thr_r, pg_lo_thr_r, pg_hi_thr_r;
  logic [15:0] cmd_rdata_r;
  logic [REF_W-1:0] ref_code_r;
  logic [2:0] freq_sel_r;
  logic [9:0] fs_tab [10] = '{10'h003, 10'h00a, 10'h012, 10'h01b, 10'h026, 10'h038,
    10'h056, 10'h085, 10'h0cd, 10'h190};
  logic [2:0] f_tab [10] = '{FREQ_250K, FREQ_250K, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
    FREQ_1000K, FREQ_1000K};
  logic [7:0] rb_code [5] = '{CMD_ON_OFF_CFG, CMD_TON_RISE, CMD_MARGIN_HIGH, CMD_MARGIN_LOW,
    CMD_FAULT_PCT};
  logic [15:0] rb_val [5] = '{ON_OFF_CFG_RST, TON_RISE_RST, MARGIN_HIGH_RST, MARGIN_LOW_RST,
    FAULT_PCT_RST};
  integer seed = 32'hf424_0ed8;
  int error_cnt = 0;
  int n_checks = 0;
  int k;
  logic [31:0] sum;

  bsrc_sequencer #(.AVG_LOG2(3)) i_dut (.clk_sys, .arst_n, .uvlo_ok, .control_input_pin,
    .ref_over_fdbk, .pg_in_window, .ov_detect, .switch_pulse, .vout_valid, .vout_sample,
    .fs_valid, .fs_kohm, .cmd_wr, .cmd_rd, .cmd_code, .cmd_wdata, .cmd_ack_r, .cmd_err_r,
    .cmd_rdata_r, .convert_en_r, .switching_en_r, .ls_on_step_r(), .ls_complementary_r,
    .ls_force_on_r, .ov_fault_r, .ref_code_r, .ov_thr_r, .uv_thr_r, .pg_lo_thr_r,
    .pg_hi_thr_r, .power_good_output_o, .power_good_output_oe_r, .freq_sel_r);

  bsrc_stage_model i_stage (.clk_sys, .arst_n, .switching_en_r, .ref_code_r, .prebias_code,
    .ref_over_fdbk, .pg_in_window, .switch_pulse);

  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_checks++;
    if (got !== want) begin
      error_cnt++;
      $display("ERROR t=%0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rst(input int n);
    @(negedge clk_sys);
    arst_n = 1'h0;
    repeat (n) @(negedge clk_sys);
    arst_n = 1'h1;
  endtask

  // Strobe stays up across back-to-back calls; idle drops it one edge later
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd,
      input logic err, input logic [15:0] rd_exp);
    @(negedge clk_sys);
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_code = code;
    cmd_wdata = wd;
    exp_q.push_back('{!wr, err, rd_exp});
  endtask

  task automatic idle(input int n);
    @(negedge clk_sys);
    cmd_wr = 1'h0;
    cmd_rd = 1'h0;
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic wait_ref(input logic [REF_W-1:0] want);
    for (k = 0; k < 20000 && ref_code_r !== want; k++) @(negedge clk_sys);
    chk(ref_code_r, want);
  endtask

  always @(negedge clk_sys) begin
    if (cmd_ack_r === 1'h1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("ERROR t=%0t unexpected answer", $time);
      end else begin
        e = exp_q.pop_front();
        chk(cmd_err_r, e.err);
        if (e.rd && !e.err) chk(cmd_rdata_r, e.data);
      end
    end
  end

  initial begin
    repeat (95000) @(posedge clk_sys);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    rst(20);
    for (int i = 0; i < 32; i++) begin
      if (i > 0) rst(2);
      fs_kohm = fs_tab[i % 10];
      uvlo_ok = 1'h0;
      cmd(1'h1, CMD_ON_OFF_CFG, {14'h0000, i[1:0]}, 1'h0, 16'h0000);
      fs_kohm = 10'h3ff;
      cmd(1'h1, CMD_OPERATION, {8'h00, i[3], 7'h00}, 1'h0, 16'h0000);
      uvlo_ok = i[4];
      control_input_pin = i[2];
      idle(6);
      chk(convert_en_r, i[4] & (!i[0] | i[2]) & (!i[1] | i[3]));
      chk(freq_sel_r, f_tab[i % 10]);
    end
    rst(2);
    uvlo_ok = 1'h0;
    for (int i = 0; i < 5; i++) cmd(1'h0, rb_code[i], 16'h0000, 1'h0, rb_val[i]);
    cmd(1'h0, 8'h55, 16'h0000, 1'h1, 16'h0000);
    cmd(1'h1, CMD_VOUT_RDG, 16'h1234, 1'h1, 16'h0000);
    idle(0);
    sum = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      vout_sample = 16'($random(seed)) & 16'h0fff;
      vout_valid = 1'h1;
      sum = sum + vout_sample;
      @(negedge clk_sys);
      vout_valid = 1'h0;
    end
    idle(4);
    cmd(1'h0, CMD_VOUT_RDG, 16'h0000, 1'h0, sum[18:3]);
    idle(0);
    ov_detect = 1'h1;
    cmd(1'h1, CMD_CLEAR_FAULT, 16'h0000, 1'h0, 16'h0000);
    idle(1);
    ov_detect = 1'h0;
    idle(1);
    chk(ov_fault_r, 1'h1);
    chk(ls_force_on_r, 1'h1);
    cmd(1'h1, CMD_CLEAR_FAULT, 16'h0000, 1'h0, 16'h0000);
    idle(1);
    chk(ov_fault_r, 1'h0);
    control_input_pin = 1'h1;
    cmd(1'h1, CMD_TON_DELAY, 16'h0001, 1'h0, 16'h0000);
    cmd(1'h1, CMD_TON_RISE, 16'h0000, 1'h0, 16'h0000);
    cmd(1'h1, CMD_REF_TRIM, 16'h0005, 1'h0, 16'h0000);
    cmd(1'h1, CMD_OPERATION, 16'h00a0, 1'h0, 16'h0000);
    idle(0);
    uvlo_ok = 1'h1;
    // One delay unit is 307 ramp ticks of 100 cycles each at the fastest rise setting
    repeat (30500) @(negedge clk_sys);
    chk(convert_en_r, 1'h0);
    for (k = 0; k < 600 && convert_en_r !== 1'h1; k++) @(negedge clk_sys);
    chk(convert_en_r, 1'h1);
    for (k = 0; k < 40000 && power_good_output_oe_r !== 1'h0; k++) @(negedge clk_sys);
    chk(power_good_output_oe_r, 1'h0);
    chk(ref_code_r, REF_NOM + 10'h005 + 10'(MARGIN_HIGH_RST));
    chk(ls_complementary_r, 1'h1);
    cmd(1'h1, CMD_REF_TRIM, 16'h0040, 1'h0, 16'h0000);
    cmd(1'h1, CMD_MARGIN_LOW, 16'h00ce, 1'h0, 16'h0000);
    cmd(1'h1, CMD_OPERATION, 16'h0080, 1'h0, 16'h0000);
    idle(0);
    wait_ref(REF_NOM + 10'(TRIM_MIN));
    cmd(1'h1, CMD_OPERATION, 16'h0090, 1'h0, 16'h0000);
    idle(0);
    wait_ref(REF_NOM + 10'(TOTAL_MIN));
    chk(convert_en_r, 1'h1);
    // Limits from the reset percentages of nominal: 16, 16 and 8 of 128
    chk(ov_thr_r, 10'h159);
    chk(uv_thr_r, 10'h10d);
    chk(pg_lo_thr_r, 10'h120);
    chk(pg_hi_thr_r, 10'h146);
    control_input_pin = 1'h0;
    idle(10);
    chk(convert_en_r, 1'h0);
    chk(power_good_output_oe_r, 1'h1);
    stop_test();
  end
endmodule
